// ---- rtl/sca_defines.svh ----
/*
 * Register offsets, field positions, reset values, write masks, command codes
 * and timing figures of the sensor configuration and alert block.
 * Assumes it is included by bare name and holds definitions only.
 */
`ifndef SCA_DEFINES_SVH
`define SCA_DEFINES_SVH

`define SCA_REG_RES 4'h0
`define SCA_REG_PER 4'h2
`define SCA_REG_AEN 4'h3
`define SCA_REG_THR_LO 4'h5
`define SCA_REG_THR_HI 4'h6
`define SCA_REG_THT_LO 4'h7
`define SCA_REG_THT_HI 4'h8
`define SCA_REG_TLT_LO 4'h9
`define SCA_REG_TLT_HI 4'ha
`define SCA_REG_TLR_LO 4'hb
`define SCA_REG_TLR_HI 4'hc
`define SCA_REG_LAST 8'h0c

`define SCA_MASK_RES 8'h0f
`define SCA_MASK_PER 8'hb1
`define SCA_MASK_AEN 8'h0f
`define SCA_MASK_HI 8'h3f
`define SCA_MASK_LO 8'hff

`define SCA_RST_RES 8'h0f
`define SCA_RST_PER 8'h11
`define SCA_RST_OTHER 8'h00

`define SCA_BIT_PER_ON 7
`define SCA_BIT_POL 0
`define SCA_BIT_EN_HL 0
`define SCA_BIT_EN_HH 1
`define SCA_BIT_EN_TL 2
`define SCA_BIT_EN_TH 3

`define SCA_CMD_WRITE 8'ha6
`define SCA_CMD_READ 8'ha7
`define SCA_CMD_STOP 8'h30
`define SCA_DEV_ADDR 7'h54

`define SCA_CLK_KHZ 125000
`define SCA_PER_HALF_MS 500
`define SCA_PER_ONE_MS 1000
`define SCA_PER_LONG_MS 2500

`endif

// ---- rtl/sca_pkg.sv ----
/*
 * Types of the sensor configuration and alert block.
 * Assumes nothing of its surroundings.
 */
package sca_pkg;
	typedef enum logic [2:0] {
		SCA_IDLE,
		SCA_ADDR,
		SCA_ADDR_ACK,
		SCA_RX,
		SCA_RX_ACK,
		SCA_TX,
		SCA_TX_ACK
	} sca_bus_state_e;
	typedef logic [13:0] sca_sample_t;
endpackage : sca_pkg

// ---- rtl/sca_regs.sv ----
/*
 * Configuration register bank, periodic measurement timer and threshold alert
 * logic of a humidity and temperature sensor, reached over a two-wire serial
 * slave with register write, register read, stop and data fetch sequences.
 * Assumes open-drain pins resolved outside and a converter on the same clock
 * that answers meas_start with one meas_done pulse and fresh samples.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sca_defines.svh"

module sca_regs #(
	parameter logic [6:0] DEV_ADDR = `SCA_DEV_ADDR,
	parameter int unsigned PER_HALF_CYC = `SCA_PER_HALF_MS * `SCA_CLK_KHZ,
	parameter int unsigned PER_ONE_CYC = `SCA_PER_ONE_MS * `SCA_CLK_KHZ,
	parameter int unsigned PER_LONG_CYC = `SCA_PER_LONG_MS * `SCA_CLK_KHZ
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic meas_done,
	input wire sca_pkg::sca_sample_t meas_temp,
	input wire sca_pkg::sca_sample_t meas_hum,
	input wire logic hum_over_in,
	input wire logic hum_under_in,
	output logic meas_start,
	output logic [3:0] temp_res_bits,
	output logic [3:0] hum_res_bits,
	output logic temp_over_flag,
	output logic temp_under_flag,
	output logic humidity_over_flag,
	output logic humidity_under_flag,
	output logic alert_pin
);
	import sca_pkg::*;

	function automatic logic [3:0] res_bits(input logic [1:0] code);
		unique case (code)
			2'h0: res_bits = 4'h8;
			2'h1: res_bits = 4'ha;
			2'h2: res_bits = 4'hc;
			2'h3: res_bits = 4'he;
		endcase
	endfunction : res_bits

	function automatic logic [7:0] reg_mask(input logic [3:0] a);
		case (a)
			`SCA_REG_RES: reg_mask = `SCA_MASK_RES;
			`SCA_REG_PER: reg_mask = `SCA_MASK_PER;
			`SCA_REG_AEN: reg_mask = `SCA_MASK_AEN;
			`SCA_REG_THR_LO, `SCA_REG_THT_LO, `SCA_REG_TLT_LO, `SCA_REG_TLR_LO:
				reg_mask = `SCA_MASK_LO;
			`SCA_REG_THR_HI, `SCA_REG_THT_HI, `SCA_REG_TLT_HI, `SCA_REG_TLR_HI:
				reg_mask = `SCA_MASK_HI;
			default: reg_mask = 8'h00;
		endcase
	endfunction : reg_mask

	function automatic logic [13:0] pair(input logic [7:0] hi, input logic [7:0] lo);
		pair = {hi[5:0], lo};
	endfunction : pair

	logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
	logic scl_rise, scl_fall, bus_start, bus_stop;
	sca_bus_state_e state;
	logic [2:0] bitcnt;
	logic got8;
	logic [7:0] shreg;
	logic rw;
	logic [1:0] rx_idx;
	logic [7:0] cmd;
	logic [7:0] ptr;
	logic [2:0] tx_idx;
	logic wr_stb;
	logic [7:0] wr_data;
	logic stop_stb;
	logic [7:0] regs [0:12];
	logic periodic_on;
	logic [31:0] per_cnt;
	logic meas_busy;
	sca_sample_t last_temp, last_hum;
	logic [7:0] next_tx_byte;
	logic [7:0] rd_value;
	logic [3:0] en;
	logic any_en;
	logic next_alert_pin;
	logic [31:0] per_len;

	// Two flip-flops before any logic; the third stage only serves edges.
	always_ff @(posedge clk) begin
		if (rst) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_d <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_s1 <= scl_in;
			scl_s2 <= scl_s1;
			scl_d <= scl_s2;
			sda_s1 <= sda_in;
			sda_s2 <= sda_s1;
			sda_d <= sda_s2;
		end
	end

	assign scl_rise = scl_s2 & ~scl_d;
	assign scl_fall = ~scl_s2 & scl_d;
	assign bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
	assign bus_stop = scl_s2 & scl_d & ~sda_d & sda_s2;
	assign en = regs[`SCA_REG_AEN][3:0];
	assign any_en = |en;

	// Register read value; bit 7 of the periodic register shows activity.
	always_comb begin
		rd_value = 8'h00;
		if (ptr <= `SCA_REG_LAST) begin
			rd_value = regs[ptr[3:0]];
		end
		if (ptr == {4'h0, `SCA_REG_PER}) begin
			rd_value[`SCA_BIT_PER_ON] = periodic_on;
		end
	end

	// Byte handed to the host for the current read position.
	always_comb begin
		next_tx_byte = 8'hff;
		if (cmd == `SCA_CMD_READ && !periodic_on) begin
			if (tx_idx == 3'h0) begin
				next_tx_byte = rd_value;
			end
		end else if (periodic_on) begin
			unique case (any_en ? tx_idx : tx_idx + 3'h1)
				3'h0: next_tx_byte = {temp_over_flag, temp_under_flag, humidity_over_flag,
					humidity_under_flag, 4'h0};
				3'h1: next_tx_byte = {2'h0, last_hum[13:8]};
				3'h2: next_tx_byte = last_hum[7:0];
				3'h3: next_tx_byte = {2'h0, last_temp[13:8]};
				3'h4: next_tx_byte = last_temp[7:0];
				default: next_tx_byte = 8'hff;
			endcase
		end
	end

	// Serial slave: address, command bytes, register data and fetch bytes.
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= SCA_IDLE;
			bitcnt <= 3'h0;
			got8 <= 1'b0;
			shreg <= 8'h00;
			rw <= 1'b0;
			rx_idx <= 2'h0;
			cmd <= 8'h00;
			ptr <= 8'h00;
			tx_idx <= 3'h0;
			wr_stb <= 1'b0;
			wr_data <= 8'h00;
			stop_stb <= 1'b0;
			sda_oe_n <= 1'b1;
			sda_out <= 1'b0;
		end else begin
			wr_stb <= 1'b0;
			stop_stb <= 1'b0;
			if (bus_stop) begin
				state <= SCA_IDLE;
				sda_oe_n <= 1'b1;
				if (rw) begin
					cmd <= 8'h00;
				end
			end else if (bus_start) begin
				state <= SCA_ADDR;
				bitcnt <= 3'h0;
				got8 <= 1'b0;
				sda_oe_n <= 1'b1;
			end else if (scl_rise) begin
				if (state == SCA_ADDR || state == SCA_RX) begin
					shreg <= {shreg[6:0], sda_s2};
					bitcnt <= bitcnt + 3'h1;
					got8 <= (bitcnt == 3'h7);
				end else if (state == SCA_TX_ACK) begin
					if (sda_s2) begin
						state <= SCA_IDLE;
					end else begin
						tx_idx <= tx_idx + 3'h1;
					end
				end
			end else if (scl_fall) begin
				unique case (state)
					SCA_IDLE: begin
					end
					SCA_ADDR: begin
						if (got8) begin
							got8 <= 1'b0;
							if (shreg[7:1] == DEV_ADDR) begin
								rw <= shreg[0];
								tx_idx <= 3'h0;
								if (!shreg[0]) begin
									rx_idx <= 2'h0;
								end
								sda_oe_n <= 1'b0;
								state <= SCA_ADDR_ACK;
							end else begin
								state <= SCA_IDLE;
							end
						end
					end
					SCA_RX: begin
						if (got8) begin
							got8 <= 1'b0;
							sda_oe_n <= 1'b0;
							state <= SCA_RX_ACK;
							if (rx_idx != 2'h3) begin
								rx_idx <= rx_idx + 2'h1;
							end
							unique case (rx_idx)
								2'h0: begin
									if (periodic_on) begin
										cmd <= 8'h00;
										stop_stb <= (shreg == `SCA_CMD_STOP);
									end else begin
										cmd <= shreg;
									end
								end
								2'h1: ptr <= shreg;
								2'h2: begin
									if (cmd == `SCA_CMD_WRITE && !periodic_on) begin
										wr_stb <= 1'b1;
										wr_data <= shreg;
									end
								end
								2'h3: begin
								end
							endcase
						end
					end
					SCA_ADDR_ACK: begin
						if (rw) begin
							shreg <= next_tx_byte;
							sda_oe_n <= next_tx_byte[7];
							bitcnt <= 3'h0;
							state <= SCA_TX;
						end else begin
							sda_oe_n <= 1'b1;
							state <= SCA_RX;
						end
					end
					SCA_RX_ACK: begin
						sda_oe_n <= 1'b1;
						state <= SCA_RX;
					end
					SCA_TX: begin
						if (bitcnt == 3'h7) begin
							sda_oe_n <= 1'b1;
							bitcnt <= 3'h0;
							state <= SCA_TX_ACK;
						end else begin
							shreg <= {shreg[6:0], 1'b0};
							sda_oe_n <= shreg[6];
							bitcnt <= bitcnt + 3'h1;
						end
					end
					SCA_TX_ACK: begin
						shreg <= next_tx_byte;
						sda_oe_n <= next_tx_byte[7];
						state <= SCA_TX;
					end
				endcase
			end
		end
	end

	// Register bank; writes keep only the implemented bits.
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i <= 12; i++) begin
				regs[i] <= `SCA_RST_OTHER;
			end
			regs[`SCA_REG_RES] <= `SCA_RST_RES;
			regs[`SCA_REG_PER] <= `SCA_RST_PER;
		end else if (wr_stb && ptr <= `SCA_REG_LAST) begin
			regs[ptr[3:0]] <= wr_data & reg_mask(ptr[3:0]);
		end
	end

	// Periodic activity: started by a write of bit 7, ended by the stop command.
	always_ff @(posedge clk) begin
		if (rst) begin
			periodic_on <= 1'b0;
		end else if (stop_stb) begin
			periodic_on <= 1'b0;
		end else if (wr_stb && ptr == {4'h0, `SCA_REG_PER} && wr_data[`SCA_BIT_PER_ON]) begin
			periodic_on <= 1'b1;
		end
	end

	// Interval length; the undefined code runs at the one second rate.
	always_comb begin
		unique case (regs[`SCA_REG_PER][5:4])
			2'h0: per_len = PER_HALF_CYC;
			2'h1: per_len = PER_ONE_CYC;
			2'h2: per_len = PER_LONG_CYC;
			2'h3: per_len = PER_ONE_CYC;
		endcase
	end

	// Measurement timer; the first measurement starts at activation.
	always_ff @(posedge clk) begin
		if (rst) begin
			per_cnt <= 32'h0;
			meas_start <= 1'b0;
			meas_busy <= 1'b0;
		end else begin
			meas_start <= 1'b0;
			if (meas_done) begin
				meas_busy <= 1'b0;
			end
			if (!periodic_on) begin
				per_cnt <= 32'h0;
			end else if (per_cnt == 32'h0) begin
				per_cnt <= per_len - 32'h1;
				meas_start <= 1'b1;
				meas_busy <= 1'b1;
			end else begin
				per_cnt <= per_cnt - 32'h1;
			end
		end
	end

	// Latest samples for the fetch sequence.
	always_ff @(posedge clk) begin
		if (rst) begin
			last_temp <= 14'h0;
			last_hum <= 14'h0;
		end else if (meas_done) begin
			last_temp <= meas_temp;
			last_hum <= meas_hum;
		end
	end

	// Temperature alerts with hysteresis, evaluated only while enabled.
	always_ff @(posedge clk) begin
		if (rst) begin
			temp_over_flag <= 1'b0;
			temp_under_flag <= 1'b0;
		end else begin
			if (!en[`SCA_BIT_EN_TH]) begin
				temp_over_flag <= 1'b0;
			end else if (meas_done) begin
				if (!temp_over_flag && meas_temp >
					pair(regs[`SCA_REG_THT_HI], regs[`SCA_REG_THT_LO])) begin
					temp_over_flag <= 1'b1;
				end else if (temp_over_flag && meas_temp <
					pair(regs[`SCA_REG_THR_HI], regs[`SCA_REG_THR_LO])) begin
					temp_over_flag <= 1'b0;
				end
			end
			if (!en[`SCA_BIT_EN_TL]) begin
				temp_under_flag <= 1'b0;
			end else if (meas_done) begin
				if (!temp_under_flag && meas_temp <
					pair(regs[`SCA_REG_TLT_HI], regs[`SCA_REG_TLT_LO])) begin
					temp_under_flag <= 1'b1;
				end else if (temp_under_flag && meas_temp >
					pair(regs[`SCA_REG_TLR_HI], regs[`SCA_REG_TLR_LO])) begin
					temp_under_flag <= 1'b0;
				end
			end
		end
	end

	// Humidity conditions arrive from their own comparators, gated here.
	always_ff @(posedge clk) begin
		if (rst) begin
			humidity_over_flag <= 1'b0;
			humidity_under_flag <= 1'b0;
		end else begin
			humidity_over_flag <= hum_over_in & en[`SCA_BIT_EN_HH];
			humidity_under_flag <= hum_under_in & en[`SCA_BIT_EN_HL];
		end
	end

	// Alert pin level from enables, flags, polarity and measurement activity.
	always_comb begin
		if (any_en) begin
			next_alert_pin = (temp_over_flag | temp_under_flag | humidity_over_flag |
				humidity_under_flag) ^ regs[`SCA_REG_PER][`SCA_BIT_POL];
		end else begin
			next_alert_pin = periodic_on ? meas_busy : 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			alert_pin <= 1'b1;
			temp_res_bits <= 4'he;
			hum_res_bits <= 4'he;
		end else begin
			alert_pin <= next_alert_pin;
			temp_res_bits <= res_bits(regs[`SCA_REG_RES][1:0]);
			hum_res_bits <= res_bits(regs[`SCA_REG_RES][3:2]);
		end
	end
endmodule : sca_regs

`default_nettype wire

// ---- tb/sca_host.sv ----
/* Two-wire host model issuing register, command and fetch sequences.
   Assumes the bench resolves the open-drain data wire with a pull-up. */
`timescale 1ns/1ps
`default_nettype none
`include "sca_defines.svh"
module sca_host (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	int miss = 0;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clk);
	endtask : w
	task automatic hw(input logic b, output logic r);
		w(2);
		sda_low <= !b;
		w(4);
		scl <= 1'b1;
		w(5);
		r = sda;
		scl <= 1'b0;
	endtask : hw
	task automatic start();
		sda_low <= 1'b0;
		w(6);
		scl <= 1'b1;
		w(5);
		sda_low <= 1'b1;
		w(5);
		scl <= 1'b0;
	endtask : start
	task automatic stop();
		w(2);
		sda_low <= 1'b1;
		w(4);
		scl <= 1'b1;
		w(5);
		sda_low <= 1'b0;
		w(5);
	endtask : stop
	task automatic tx(input logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) hw(b[i], r);
		hw(1'b1, r);
		if (r) miss++;
	endtask : tx
	task automatic rx(output logic [7:0] d);
		logic r;
		for (int i = 0; i < 8; i++) begin
			hw(1'b1, r);
			d = {d[6:0], r};
		end
		hw(1'b1, r);
	endtask : rx
	task automatic reg_write(input logic [7:0] a, v);
		start();
		tx({`SCA_DEV_ADDR, 1'b0});
		tx(`SCA_CMD_WRITE);
		tx(a);
		tx(v);
		stop();
	endtask : reg_write
	task automatic reg_read(input logic [7:0] a, output logic [7:0] v);
		start();
		tx({`SCA_DEV_ADDR, 1'b0});
		tx(`SCA_CMD_READ);
		tx(a);
		start();
		tx({`SCA_DEV_ADDR, 1'b1});
		rx(v);
		stop();
	endtask : reg_read
	task automatic cmd(input logic [7:0] c);
		start();
		tx({`SCA_DEV_ADDR, 1'b0});
		tx(c);
		stop();
	endtask : cmd
	task automatic fetch(output logic [7:0] v);
		start();
		tx({`SCA_DEV_ADDR, 1'b1});
		rx(v);
		stop();
	endtask : fetch
endmodule : sca_host
`default_nettype wire

// ---- tb/sca_regs_checker.sv ----
/* Port assertions of the configuration and alert block.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module sca_regs_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic meas_done,
	input wire logic hum_over_in,
	input wire logic hum_under_in,
	input wire logic meas_start,
	input wire logic [3:0] temp_res_bits,
	input wire logic temp_over_flag,
	input wire logic temp_under_flag,
	input wire logic humidity_over_flag,
	input wire logic humidity_under_flag,
	input wire logic alert_pin
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	wire logic others = temp_under_flag | humidity_over_flag | humidity_under_flag;
	sequence s_over_up;
		!temp_over_flag && !others ##1 temp_over_flag && !others;
	endsequence
	a_res_code: assert property (temp_res_bits inside {4'h8, 4'ha, 4'hc, 4'he})
		else $error("bad resolution");
	a_after_reset: assert property ($fell(rst) |-> alert_pin && temp_res_bits == 4'he)
		else $error("bad reset state");
	a_over_cause: assert property ($rose(temp_over_flag) |-> $past(meas_done) || $past(meas_done, 2))
		else $error("over flag without sample");
	a_under_cause: assert property ($rose(temp_under_flag) |-> $past(meas_done) || $past(meas_done, 2))
		else $error("under flag without sample");
	a_hum_over_gate: assert property (humidity_over_flag |-> $past(hum_over_in))
		else $error("humidity over flag without input");
	a_hum_under_gate: assert property (humidity_under_flag |-> $past(hum_under_in))
		else $error("humidity under flag without input");
	a_start_pulse: assert property (meas_start |=> !meas_start [*8])
		else $error("start pulses too close");
	a_pin_follows: assert property (s_over_up |=> $changed(alert_pin))
		else $error("pin ignored new flag");
endmodule : sca_regs_checker
bind sca_regs sca_regs_checker u_chk (
	.clk(clk), .rst(rst), .meas_done(meas_done), .hum_over_in(hum_over_in),
	.hum_under_in(hum_under_in), .meas_start(meas_start), .temp_res_bits(temp_res_bits),
	.temp_over_flag(temp_over_flag), .temp_under_flag(temp_under_flag),
	.humidity_over_flag(humidity_over_flag), .humidity_under_flag(humidity_under_flag),
	.alert_pin(alert_pin)
);
`default_nettype wire

// ---- tb/tb_sensor_config_alert_regs.sv ----
/* Self-checking bench for the configuration and alert block.
   Assumes the host model and checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module tb_sensor_config_alert_regs;
	import sca_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic meas_done = 1'b0;
	logic hov = 1'b0;
	logic hun = 1'b0;
	sca_sample_t meas_temp = '0;
	wire logic scl, low, sda;
	logic sda_out, sda_oe_n, meas_start, tof, tuf, hof, huf, pin;
	logic [3:0] trb, hrb;
	logic [7:0] d;
	int error_cnt = 0;
	int checks_done = 0;
	int n;
	sca_sample_t tv[9] = '{14'h1000, 14'h1001, 14'h0800, 14'h07ff,
		14'h0100, 14'h00ff, 14'h0200, 14'h0201, 14'h1100};
	logic [7:0] ev[9] = '{8'h1, 8'h4, 8'h4, 8'h1, 8'h0, 8'h3, 8'h3, 8'h0, 8'h0};
	always #4 clk = ~clk;
	assign sda = !low && (sda_oe_n || sda_out);
	sca_host u_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(low));
	sca_regs #(.PER_HALF_CYC(50), .PER_ONE_CYC(100), .PER_LONG_CYC(250)) u_dut (
		.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .meas_done(meas_done), .meas_temp(meas_temp),
		.meas_hum(meas_temp), .hum_over_in(hov), .hum_under_in(hun),
		.meas_start(meas_start), .temp_res_bits(trb), .hum_res_bits(hrb),
		.temp_over_flag(tof), .temp_under_flag(tuf), .humidity_over_flag(hof),
		.humidity_under_flag(huf), .alert_pin(pin)
	);
	task automatic chk(input logic [7:0] g, e);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, v);
		u_host.reg_write(a, v);
	endtask : wr
	task automatic rdc(input logic [7:0] a, e);
		u_host.reg_read(a, d);
		chk(d, e);
	endtask : rdc
	task automatic smp(input sca_sample_t t);
		meas_temp <= t;
		meas_done <= 1'b1;
		@(posedge clk);
		meas_done <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : smp
	task automatic wst();
		n = 0;
		while (meas_start !== 1'b1 && n < 400) begin
			@(posedge clk);
			n++;
		end
	endtask : wst
	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (60000) @(posedge clk);
		error_cnt++;
		report_and_stop();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		chk({trb, hrb}, 8'hee);
		chk({7'h0, pin}, 8'h01);
		rdc(8'h00, 8'h0f);
		rdc(8'h02, 8'h11);
		rdc(8'h03, 8'h00);
		for (n = 0; n < 4; n++) begin
			wr(8'h00, 8'(3 * n + 3));
			chk({trb, hrb}, {4'(14 - 2 * n), 4'(8 + 2 * n)});
		end
		wr(8'h08, 8'hff);
		rdc(8'h08, 8'h3f);
		wr(8'h03, 8'hff);
		rdc(8'h03, 8'h0f);
		wr(8'h0d, 8'h5a);
		rdc(8'h0d, 8'h00);
		wr(8'h03, 8'h08);
		wr(8'h08, 8'h10);
		wr(8'h06, 8'h08);
		for (n = 0; n < 9; n++) begin
			if (n == 4) begin
				wr(8'h02, 8'h10);
				wr(8'h03, 8'h04);
				wr(8'h0a, 8'h01);
				wr(8'h0c, 8'h02);
			end
			smp(tv[n]);
			chk({5'h0, tof, tuf, pin}, ev[n]);
		end
		wr(8'h03, 8'h00);
		chk({7'h0, pin}, 8'h01);
		hov <= 1'b1;
		hun <= 1'b1;
		for (n = 0; n < 3; n++) begin
			wr(8'h03, 8'(n));
			chk({6'h0, hof, huf}, 8'(n));
		end
		hov <= 1'b0;
		hun <= 1'b0;
		wr(8'h03, 8'h00);
		wr(8'h02, 8'h81);
		wst();
		chk(8'(n < 400), 8'h01);
		repeat (2) @(posedge clk);
		chk({7'h0, pin}, 8'h01);
		smp(14'h0800);
		chk({7'h0, pin}, 8'h00);
		wst();
		chk(8'(n), 8'h2c);
		u_host.cmd(8'h30);
		rdc(8'h02, 8'h01);
		wr(8'h02, 8'ha1);
		wst();
		@(posedge clk);
		wst();
		chk(8'(n), 8'hf9);
		u_host.cmd(8'h30);
		hov <= 1'b1;
		wr(8'h03, 8'h02);
		wr(8'h02, 8'h81);
		u_host.fetch(d);
		chk(d, 8'h20);
		u_host.cmd(8'h30);
		chk(u_host.miss[7:0], 8'h00);
		report_and_stop();
	end
endmodule : tb_sensor_config_alert_regs
`default_nettype wire
